// file: core/x4k_key_builder.sv
// Builds the label-stack, IP and payload part of the four-word lookup key
// Operation
// - Key type code: 0 multi-layer, 1 triple label, 2 IPv4 tuple, 3 custom.
// - Third stack entry label, traffic class and bottom flag go to own fields.
// - Third entry TTL expired flag set when TTL is one or less.
// - Four-bit reserved label value, meaningful only when position is not 5 (none).
// - Capture the 32 bits after the bottom-of-stack entry.
// - Position 0..2 seen or skipped, 3 seen, 5 none, 4 unused.
// - Positions count from top of stack, top is position 0.
// - Skip reserved label if per-label or per-lookup skip enable set.
// - Fragment flag when more-fragments set or offset above zero.
// - Non-first fragment flag only when fragment offset above zero.
// - Options flag when header length exceeds 5; options not parsed.
// - DSCP from frame, or classified DSCP when lookup selects it.
// - Destination word: IPv4 address or IPv6 address low 32 bits.
// - LLC source word: control byte then payload bytes 0 to 2.
// - SNAP source word: protocol id bytes then payload byte 0.
// - Typed frames: IPv4 source, IPv6 source low bits, else payload 0..3.
// - Protocol field: IPv4 protocol or IPv6 next header.
// - Eight range checkers use frame values, remapped DSCP for DSCP.
// - Payload word taken 20 bytes after IPv4 header start always.
// - Custom field is 15 bytes from the current frame pointer.
// - Ethernet frames start custom bytes after MACs, tags and EtherType.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module x4k_key_builder
  import x4k_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire x4k_frame_t  frame_in,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output x4k_key_t         key_q,
  output logic             key_valid_q,
  output logic [31:0]      reg_rdata_q
);

  // Configuration and status state
  logic [LOOKUPS-1:0]  lookup_skip_q;
  logic [LOOKUPS-1:0]  use_cl_dscp_q;
  logic [15:0]         label_skip_q;
  logic [NUM_RNG-1:0][15:0] rng_lo_q;
  logic [NUM_RNG-1:0][15:0] rng_hi_q;
  logic [NUM_RNG-1:0][2:0]  rng_kind_q;
  logic [15:0]         key_count_q;
  logic [2:0]          last_pos_q;

  // Register decode
  wire       wr_ctrl    = reg_wr && (reg_addr == REG_CTRL);
  wire       wr_lskip   = reg_wr && (reg_addr == REG_LABEL_SKIP);
  wire [7:0] rng_base   = reg_addr & RNG_IDX_MASK;
  wire [2:0] rng_sel    = reg_addr[4:2];
  wire       hit_bound  = (rng_base == REG_RNG_BOUND);
  wire       hit_kind   = (rng_base == REG_RNG_KIND);
  wire       wr_bound   = reg_wr && hit_bound;
  wire       wr_kind    = reg_wr && hit_kind;

  wire [31:0] rd_ctrl   = {24'h000000, use_cl_dscp_q, lookup_skip_q};
  wire [31:0] rd_lskip  = {16'h0000, label_skip_q};
  wire [31:0] rd_status = {13'h0000, last_pos_q, key_count_q};
  wire [31:0] rd_bound  = {rng_hi_q[rng_sel], rng_lo_q[rng_sel]};
  wire [31:0] rd_kind   = {29'h00000000, rng_kind_q[rng_sel]};
  // Unmapped addresses read as zero
  wire [31:0] rd_mux    =
    (reg_addr == REG_CTRL)       ? rd_ctrl   :
    (reg_addr == REG_LABEL_SKIP) ? rd_lskip  :
    (reg_addr == REG_STATUS)     ? rd_status :
    hit_bound                    ? rd_bound  :
    hit_kind                     ? rd_kind   : 32'h00000000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lookup_skip_q <= 4'h0;
      use_cl_dscp_q <= 4'h0;
      label_skip_q  <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        lookup_skip_q <= reg_wdata[3:0];
        use_cl_dscp_q <= reg_wdata[7:4];
      end
      if (wr_lskip) begin
        label_skip_q <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rng_lo_q   <= '0;
      rng_hi_q   <= '0;
      rng_kind_q <= '0;
    end else begin
      if (wr_bound) begin
        rng_lo_q[rng_sel] <= reg_wdata[15:0];
        rng_hi_q[rng_sel] <= reg_wdata[31:16];
      end
      if (wr_kind) begin
        rng_kind_q[rng_sel] <= reg_wdata[2:0];
      end
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 32'h00000000;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // Label stack scan, entry 0 is the top of stack
  logic [SCAN_WORDS-1:0] is_rsv;
  logic [SCAN_WORDS-1:0] is_bos;
  genvar gi;
  generate
    for (gi = 0; gi < SCAN_WORDS; gi++) begin : g_scan
      assign is_rsv[gi] =
        frame_in.stack[gi][LBL_HI:LBL_LO] < RSV_LBL_LIMIT;
      assign is_bos[gi] = frame_in.stack[gi][BOS_BIT];
    end
  endgenerate

  // Only the first reserved label counts
  wire [2:0] rsv_pos =
    is_rsv[0] ? 3'h0 :
    is_rsv[1] ? 3'h1 :
    is_rsv[2] ? 3'h2 :
    is_rsv[3] ? RSV_POS_LAST : RSV_POS_NONE;
  wire       rsv_seen = (rsv_pos != RSV_POS_NONE);
  wire [1:0] rsv_idx  = rsv_pos[1:0];
  wire [3:0] rsv_val  =
    rsv_seen ? frame_in.stack[rsv_idx][LBL_LO+3:LBL_LO] : 4'h0;
  wire       skip_en  = label_skip_q[rsv_val] |
                        lookup_skip_q[frame_in.lookup_idx];
  // A skipped label at or above the third entry pulls the next one up
  wire       skipped  = rsv_seen && skip_en && (rsv_pos < RSV_POS_LAST);
  wire [1:0] third_ix = skipped ? THIRD_IDX_SKIP : THIRD_IDX;
  wire [31:0] third_w = frame_in.stack[third_ix];

  wire [31:0] cw_word =
    is_bos[0] ? frame_in.stack[1] :
    is_bos[1] ? frame_in.stack[2] :
    is_bos[2] ? frame_in.stack[3] :
    is_bos[3] ? frame_in.stack[4] : 32'h00000000;

  // IPv4 flags
  wire frag_gt0  = (frame_in.frag_ofs != 13'h0000);
  wire is_v4     = frame_in.is_ipv4_flag;
  wire frag_flag = is_v4 && (frame_in.more_frags || frag_gt0);
  wire nfirst    = is_v4 && frag_gt0;
  wire opts      = is_v4 && (frame_in.ihl > IHL_NO_OPTS);

  wire [5:0] dscp_sel = use_cl_dscp_q[frame_in.lookup_idx] ?
                        frame_in.cl_dscp : frame_in.frame_dscp;

  // Byte gathers from the payload window; indices wrap within it
  wire [5:0] eth_len  = ETH_BASE_LEN + VLAN_LEN * {4'h0, frame_in.vlan_cnt};
  wire [5:0] cust_ofs = frame_in.frame_ptr +
                        (frame_in.is_eth ? eth_len : 6'h00);
  wire [5:0] pay_ofs  = frame_in.l3_ofs + IP_PAYLOAD_OFS;
  logic [WORD_BYTES-1:0][7:0]   l3_bytes;
  logic [WORD_BYTES-1:0][7:0]   ipp_bytes;
  logic [CUSTOM_BYTES-1:0][7:0] cust_bytes;
  generate
    for (gi = 0; gi < WORD_BYTES; gi++) begin : g_word
      localparam logic [5:0] OFS = 6'(gi);
      assign l3_bytes[WORD_BYTES-1-gi] =
        frame_in.window[frame_in.l3_ofs + OFS];
      assign ipp_bytes[WORD_BYTES-1-gi] =
        frame_in.window[pay_ofs + OFS];
    end
    for (gi = 0; gi < CUSTOM_BYTES; gi++) begin : g_cust
      localparam logic [5:0] OFS = 6'(gi);
      assign cust_bytes[CUSTOM_BYTES-1-gi] =
        frame_in.window[cust_ofs + OFS];
    end
  endgenerate

  wire llc_frm  = !frame_in.type_not_length_flag &&
                  !frame_in.ip_or_snap_flag;
  wire snap_frm = !frame_in.type_not_length_flag &&
                  frame_in.ip_or_snap_flag;
  wire ip_frm   = frame_in.type_not_length_flag &&
                  frame_in.ip_or_snap_flag;
  wire [31:0] sip_word =
    llc_frm  ? {frame_in.llc_ctrl, l3_bytes[3:1]} :
    snap_frm ? {frame_in.snap_pid, l3_bytes[3]} :
    !ip_frm  ? l3_bytes :
    is_v4    ? frame_in.ip4_sip : frame_in.ip6_sip_lo;
  wire [31:0] dip_word = is_v4 ? frame_in.ip4_dip :
                         frame_in.ip6_dip_lo;
  wire [7:0]  proto    = is_v4 ? frame_in.ip4_proto :
                         frame_in.ip6_next;

  // Range checkers; the DSCP kind compares the remapped value
  logic [NUM_RNG-1:0] rng_hit;
  generate
    for (gi = 0; gi < NUM_RNG; gi++) begin : g_rng
      wire [15:0] lo = rng_lo_q[gi];
      wire [15:0] hi = rng_hi_q[gi];
      wire in_s = (frame_in.sport >= lo) && (frame_in.sport <= hi);
      wire in_d = (frame_in.dport >= lo) && (frame_in.dport <= hi);
      wire [15:0] v_vid  = {4'h0, frame_in.vid};
      wire [15:0] v_dscp = {10'h000, frame_in.remap_dscp};
      wire in_v = (v_vid >= lo) && (v_vid <= hi);
      wire in_q = (v_dscp >= lo) && (v_dscp <= hi);
      wire in_c = (frame_in.rng_custom >= lo) &&
                  (frame_in.rng_custom <= hi);
      wire [2:0] k = rng_kind_q[gi];
      assign rng_hit[gi] =
        (k == RK_SPORT)  ? in_s :
        (k == RK_DPORT)  ? in_d :
        (k == RK_EITHER) ? (in_s || in_d) :
        (k == RK_VID)    ? in_v :
        (k == RK_DSCP)   ? in_q :
        (k == RK_CUSTOM) ? in_c : 1'b0;
    end
  endgenerate

  // Which field groups belong to the selected key
  wire kt_tri  = (frame_in.key_type == KT_TRIPLE_LBL);
  wire kt_5t   = (frame_in.key_type == KT_IPV4_5TUP);
  wire kt_cust = (frame_in.key_type == KT_CUSTOM);
  wire kt_ip   = kt_tri || kt_5t;

  x4k_key_t key_d;
  always_comb begin
    key_d = '0;
    key_d.key_type_selector = frame_in.key_type;
    if (kt_tri) begin
      key_d.third_label_value         = third_w[LBL_HI:LBL_LO];
      key_d.third_label_traffic_class = third_w[TC_HI:TC_LO];
      key_d.third_label_bottom_flag   = third_w[BOS_BIT];
      key_d.third_label_ttl_expired   =
        third_w[TTL_HI:0] <= TTL_EXPIRE_MAX;
      key_d.reserved_label_value      = rsv_val;
      key_d.control_word_after_stack  = cw_word;
      key_d.reserved_label_position   = rsv_pos;
    end
    if (kt_ip) begin
      key_d.ipv4_fragment_flag       = frag_flag;
      key_d.ipv4_non_first_fragment  = nfirst;
      key_d.ipv4_has_options         = opts;
      key_d.dscp_key_field           = dscp_sel;
      key_d.destination_address_word = dip_word;
      key_d.source_address_word      = sip_word;
      key_d.protocol_key_field       = proto;
      key_d.range_match_mask         = rng_hit;
    end
    if (kt_5t) begin
      key_d.fixed_offset_payload_word = ipp_bytes;
    end
    if (kt_cust) begin
      key_d.custom_payload_bytes = cust_bytes;
    end
  end

  // Key holds until the next valid frame so the engine may sample late
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_q       <= '0;
      key_valid_q <= 1'b0;
    end else begin
      key_valid_q <= frame_in.valid;
      if (frame_in.valid) begin
        key_q <= key_d;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_count_q <= 16'h0000;
      last_pos_q  <= RSV_POS_NONE;
    end else if (frame_in.valid) begin
      key_count_q <= key_count_q + 16'h0001;
      last_pos_q  <= rsv_pos;
    end
  end

  // Checks
  ttl_expiry_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_tri |=> key_valid_q &&
      key_q.third_label_ttl_expired ==
      ($past(third_w[TTL_HI:0]) <= TTL_EXPIRE_MAX))
    else $error("third label ttl flag wrong");

  rsv_pos_code_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_tri && (is_rsv == 4'h0) |=>
      key_q.reserved_label_position == RSV_POS_NONE)
    else $error("reserved position not none");

  rsv_top_pos_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_tri && is_rsv[0] |=>
      key_q.reserved_label_position == 3'h0)
    else $error("top reserved label not at position zero");

  frag_flags_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip && is_v4 && frag_gt0 |=>
      key_q.ipv4_non_first_fragment && key_q.ipv4_fragment_flag)
    else $error("fragment flags wrong");

  options_flag_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip |=>
      key_q.ipv4_has_options ==
      ($past(is_v4) && ($past(frame_in.ihl) > IHL_NO_OPTS)))
    else $error("options flag wrong");

  dscp_select_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip && use_cl_dscp_q[frame_in.lookup_idx] |=>
      key_q.dscp_key_field == $past(frame_in.cl_dscp))
    else $error("classified dscp not used");

  dip_word_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip && is_v4 |=>
      key_q.destination_address_word == $past(frame_in.ip4_dip))
    else $error("destination word wrong");

  key_type_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid |=> key_valid_q &&
      key_q.key_type_selector == $past(frame_in.key_type))
    else $error("key type not carried");

  third_unskipped_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_tri && !skip_en |=>
      key_q.third_label_value ==
      $past(frame_in.stack[THIRD_IDX][LBL_HI:LBL_LO]))
    else $error("third label taken from wrong entry");

  cw_after_top_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_tri && is_bos[0] |=>
      key_q.control_word_after_stack == $past(frame_in.stack[1]))
    else $error("control word not after bottom entry");

  more_frag_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip && is_v4 && frame_in.more_frags |=>
      key_q.ipv4_fragment_flag)
    else $error("more fragments not flagged");

  llc_source_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip && llc_frm |=>
      key_q.source_address_word[31:24] == $past(frame_in.llc_ctrl))
    else $error("llc control byte misplaced");

  ip_proto_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_ip && is_v4 |=>
      key_q.protocol_key_field == $past(frame_in.ip4_proto))
    else $error("protocol field wrong");

  payload_ofs_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && kt_5t |=>
      key_q.fixed_offset_payload_word[31:24] ==
      $past(frame_in.window[frame_in.l3_ofs + IP_PAYLOAD_OFS]))
    else $error("payload word offset wrong");

  unused_zero_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    frame_in.valid && !kt_cust |=>
      key_q.custom_payload_bytes == '0)
    else $error("custom bytes not cleared");

  read_timing_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && (reg_addr == REG_STATUS) |=>
      reg_rdata_q[15:0] == $past(key_count_q) + 16'h0001 ||
      reg_rdata_q[15:0] == $past(key_count_q))
    else $error("status read wrong");

endmodule // x4k_key_builder

// file: core/x4k_pkg.sv
// Shared constants and carriers for the four-word lookup key builder
package x4k_pkg;
  // Key type selector codes
  localparam logic [1:0] KT_MULTI_LAYER = 2'h0;
  localparam logic [1:0] KT_TRIPLE_LBL  = 2'h1;
  localparam logic [1:0] KT_IPV4_5TUP   = 2'h2;
  localparam logic [1:0] KT_CUSTOM      = 2'h3;
  // Label stack entry layout and reserved-label handling
  localparam int         LBL_HI         = 31;
  localparam int         LBL_LO         = 12;
  localparam int         TC_HI          = 11;
  localparam int         TC_LO          = 9;
  localparam int         BOS_BIT        = 8;
  localparam int         TTL_HI         = 7;
  localparam int         STACK_WORDS    = 5;
  localparam int         SCAN_WORDS     = 4;
  localparam logic [19:0] RSV_LBL_LIMIT = 20'h00010;
  localparam logic [7:0] TTL_EXPIRE_MAX = 8'h01;
  localparam logic [2:0] RSV_POS_LAST   = 3'h3;
  localparam logic [2:0] RSV_POS_NONE   = 3'h5;
  localparam logic [1:0] THIRD_IDX      = 2'h2;
  localparam logic [1:0] THIRD_IDX_SKIP = 2'h3;
  // IPv4 header figures
  localparam logic [3:0] IHL_NO_OPTS    = 4'h5;
  localparam logic [5:0] IP_PAYLOAD_OFS = 6'h14;
  // Payload window and custom extraction
  localparam int         WIN_BYTES      = 64;
  localparam int         CUSTOM_BYTES   = 15;
  localparam int         WORD_BYTES     = 4;
  localparam logic [5:0] ETH_BASE_LEN   = 6'h0E;
  localparam logic [5:0] VLAN_LEN       = 6'h04;
  // Range checkers
  localparam int         NUM_RNG        = 8;
  localparam int         LOOKUPS        = 4;
  localparam logic [2:0] RK_SPORT       = 3'h0;
  localparam logic [2:0] RK_DPORT       = 3'h1;
  localparam logic [2:0] RK_EITHER      = 3'h2;
  localparam logic [2:0] RK_VID         = 3'h3;
  localparam logic [2:0] RK_DSCP        = 3'h4;
  localparam logic [2:0] RK_CUSTOM      = 3'h5;
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_LABEL_SKIP = 8'h04;
  localparam logic [7:0] REG_STATUS     = 8'h08;
  localparam logic [7:0] REG_RNG_BOUND  = 8'h20;
  localparam logic [7:0] REG_RNG_KIND   = 8'h40;
  localparam logic [7:0] RNG_IDX_MASK   = 8'hE3;

  typedef struct packed {
    logic                  valid;
    logic [1:0]            key_type;
    logic [1:0]            lookup_idx;
    logic [STACK_WORDS-1:0][31:0] stack;
    logic                  type_not_length_flag;
    logic                  ip_or_snap_flag;
    logic                  is_ipv4_flag;
    logic                  more_frags;
    logic [12:0]           frag_ofs;
    logic [3:0]            ihl;
    logic [5:0]            frame_dscp;
    logic [5:0]            cl_dscp;
    logic [5:0]            remap_dscp;
    logic [31:0]           ip4_sip;
    logic [31:0]           ip4_dip;
    logic [31:0]           ip6_sip_lo;
    logic [31:0]           ip6_dip_lo;
    logic [7:0]            ip4_proto;
    logic [7:0]            ip6_next;
    logic [7:0]            llc_ctrl;
    logic [23:0]           snap_pid;
    logic [5:0]            l3_ofs;
    logic [5:0]            frame_ptr;
    logic                  is_eth;
    logic [1:0]            vlan_cnt;
    logic [15:0]           sport;
    logic [15:0]           dport;
    logic [11:0]           vid;
    logic [15:0]           rng_custom;
    logic [WIN_BYTES-1:0][7:0] window;
  } x4k_frame_t;

  typedef struct packed {
    logic [1:0]   key_type_selector;
    logic [19:0]  third_label_value;
    logic [2:0]   third_label_traffic_class;
    logic         third_label_bottom_flag;
    logic         third_label_ttl_expired;
    logic [3:0]   reserved_label_value;
    logic [31:0]  control_word_after_stack;
    logic [2:0]   reserved_label_position;
    logic         ipv4_fragment_flag;
    logic         ipv4_non_first_fragment;
    logic         ipv4_has_options;
    logic [5:0]   dscp_key_field;
    logic [31:0]  destination_address_word;
    logic [31:0]  source_address_word;
    logic [7:0]   protocol_key_field;
    logic [NUM_RNG-1:0] range_match_mask;
    logic [31:0]  fixed_offset_payload_word;
    logic [CUSTOM_BYTES-1:0][7:0] custom_payload_bytes;
  } x4k_key_t;
endpackage

// file: test/x4k_key_builder_tb.sv
// Self-checking bench for the four-word key builder
`timescale 1ns/1ps
module x4k_key_builder_tb
  import x4k_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  x4k_frame_t  frame_in;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  x4k_key_t    key_q;
  logic        key_valid_q;
  logic [31:0] reg_rdata_q;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n_keys = 0;
  integer      seed = 32'h985F;
  logic [7:0]  ctrl_m = 8'h00;
  logic [15:0] skip_m = 16'h0000;
  logic [31:0] bnd_m [8];
  logic [2:0]  kind_m [8];
  logic [2:0]  last_pos = 3'h5;
  x4k_key_t    exp_q [$];
  x4k_key_t    msk_q [$];

  always #12.5 clk_sys = ~clk_sys;

  x4k_parser_model parser_u (
    .clk_sys (clk_sys),
    .frame_q (frame_in)
  );

  x4k_key_builder dut_u (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .frame_in    (frame_in),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .key_q       (key_q),
    .key_valid_q (key_valid_q),
    .reg_rdata_q (reg_rdata_q)
  );

  task automatic chk(input logic [319:0] seen, input logic [319:0] want);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [31:0] w4(input x4k_frame_t f,
                                     input logic [5:0] b);
    return {f.window[b], f.window[b+6'h1], f.window[b+6'h2],
            f.window[b+6'h3]};
  endfunction

  function automatic logic inr(input logic [15:0] v, input logic [31:0] r);
    return v >= r[15:0] && v <= r[31:16];
  endfunction

  function automatic logic [31:0] rexp(input logic [7:0] a);
    if (a == REG_CTRL) return {24'h0, ctrl_m};
    if (a == REG_LABEL_SKIP) return {16'h0, skip_m};
    if (a == REG_STATUS) return {13'h0, last_pos, 16'(n_keys)};
    if ((a & RNG_IDX_MASK) == REG_RNG_BOUND) return bnd_m[a[4:2]];
    if ((a & RNG_IDX_MASK) == REG_RNG_KIND) return {29'h0, kind_m[a[4:2]]};
    return 32'h0;
  endfunction

  function automatic void model(input x4k_frame_t f, output x4k_key_t k,
                                output x4k_key_t m, output int p);
    logic        sk;
    logic        v4;
    logic        v6;
    logic [31:0] e;
    logic [31:0] s;
    logic [5:0]  b;
    logic [15:0] v;
    k = '0;
    m = '0;
    p = 5;
    sk = 1'b0;
    for (int i = 3; i >= 0; i--)
      if (f.stack[i][31:12] < RSV_LBL_LIMIT) p = i;
    if (p < 3) sk = skip_m[f.stack[p][15:12]] | ctrl_m[f.lookup_idx];
    e = f.stack[sk ? 3 : 2];
    v4 = f.type_not_length_flag & f.ip_or_snap_flag & f.is_ipv4_flag;
    v6 = f.type_not_length_flag & f.ip_or_snap_flag & ~f.is_ipv4_flag;
    b = f.l3_ofs;
    k.key_type_selector = f.key_type;
    if (f.key_type == KT_TRIPLE_LBL) begin
      k.third_label_value = e[31:12];
      k.third_label_traffic_class = e[11:9];
      k.third_label_bottom_flag = e[8];
      k.third_label_ttl_expired = e[7:0] <= TTL_EXPIRE_MAX;
      k.reserved_label_position = 3'(p);
      if (p < 5) k.reserved_label_value = f.stack[p][15:12];
      else m.reserved_label_value = 4'hF;
      for (int i = 3; i >= 0; i--)
        if (f.stack[i][8]) k.control_word_after_stack = f.stack[i+1];
    end
    if (f.key_type == KT_TRIPLE_LBL || f.key_type == KT_IPV4_5TUP) begin
      k.ipv4_fragment_flag = v4 & (f.more_frags | (f.frag_ofs != 0));
      k.ipv4_non_first_fragment = v4 & (f.frag_ofs != 0);
      k.ipv4_has_options = v4 & (f.ihl > IHL_NO_OPTS);
      k.dscp_key_field = ctrl_m[4+f.lookup_idx] ? f.cl_dscp : f.frame_dscp;
      k.destination_address_word = v4 ? f.ip4_dip : f.ip6_dip_lo;
      k.protocol_key_field = v4 ? f.ip4_proto : f.ip6_next;
      // Frames without an IP header leave these fields open, so skip them
      if (!(v4 | v6)) begin
        m.dscp_key_field = '1;
        m.destination_address_word = '1;
        m.protocol_key_field = '1;
      end
      s = w4(f, b);
      if (!f.type_not_length_flag)
        k.source_address_word = f.ip_or_snap_flag ? {f.snap_pid, s[31:24]}
                                                  : {f.llc_ctrl, s[31:8]};
      else
        k.source_address_word = v4 ? f.ip4_sip : v6 ? f.ip6_sip_lo : s;
      for (int i = 0; i < NUM_RNG; i++) begin
        case (kind_m[i])
          RK_DPORT:  v = f.dport;
          RK_VID:    v = 16'(f.vid);
          RK_DSCP:   v = 16'(f.remap_dscp);
          RK_CUSTOM: v = f.rng_custom;
          default:   v = f.sport;
        endcase
        k.range_match_mask[i] = kind_m[i] < 3'h6 && inr(v, bnd_m[i])
          || kind_m[i] == RK_EITHER && inr(f.dport, bnd_m[i]);
      end
    end
    if (f.key_type == KT_IPV4_5TUP)
      k.fixed_offset_payload_word = w4(f, b + IP_PAYLOAD_OFS);
    if (f.key_type == KT_CUSTOM) begin
      b = f.frame_ptr;
      if (f.is_eth) b = b + ETH_BASE_LEN + VLAN_LEN * 6'(f.vlan_cnt);
      for (int j = 0; j < CUSTOM_BYTES; j++)
        k.custom_payload_bytes[CUSTOM_BYTES-1-j] = f.window[b + 6'(j)];
    end
  endfunction

  // Frame flags stay self-consistent; labels and TTLs lean on edge values
  function automatic x4k_frame_t rnd_frame(input logic [1:0] kt);
    logic [991:0] r;
    x4k_frame_t   f;
    int           k;
    for (int i = 0; i < 31; i++) r[32*i+:32] = $random(seed);
    f = r[$bits(x4k_frame_t)-1:0];
    k = (kt == KT_IPV4_5TUP) ? 2 : {$random(seed)} % 5;
    f.valid = 1'b1;
    f.key_type = kt;
    f.type_not_length_flag = k >= 2;
    f.ip_or_snap_flag = k > 0 && k < 4;
    f.is_ipv4_flag = k == 2;
    f.ihl = 4'h4 + 4'(f.ihl % 3);
    if (f.frag_ofs[0]) f.frag_ofs = 13'h0000;
    for (int i = 0; i < 4; i++) begin
      if (f.stack[i][0]) f.stack[i][31:12] = 20'(f.stack[i][4:1]);
      if (f.stack[i][5]) f.stack[i][7:0] = 8'(f.stack[i][11:10]);
    end
    return f;
  endfunction

  task automatic push(input x4k_frame_t f);
    x4k_key_t k;
    x4k_key_t m;
    int       p;
    model(f, k, m, p);
    exp_q.push_back(k);
    msk_q.push_back(m);
    last_pos = 3'(p);
    n_keys++;
    parser_u.pend_q.push_back(f);
  endtask

  task automatic burst(input int n, input logic [1:0] kt);
    repeat (n) begin
      @(negedge clk_sys);
      push(rnd_frame(kt));
      if (seed[0]) @(negedge clk_sys);
    end
  endtask

  task automatic drain();
    int t;
    t = 0;
    while (exp_q.size() > 0 && t < 1000) begin
      @(negedge clk_sys);
      t++;
    end
    if (exp_q.size() > 0) begin
      chk(320'(exp_q.size()), 320'(0));
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    if (a == REG_CTRL) ctrl_m = d[7:0];
    if (a == REG_LABEL_SKIP) skip_m = d[15:0];
    if ((a & RNG_IDX_MASK) == REG_RNG_BOUND) bnd_m[a[4:2]] = d;
    if ((a & RNG_IDX_MASK) == REG_RNG_KIND) kind_m[a[4:2]] = d[2:0];
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    chk(320'(reg_rdata_q), 320'(rexp(a)));
  endtask

  always @(negedge clk_sys) begin
    logic [319:0] g;
    logic [319:0] e;
    if (key_valid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(320'(1), 320'(0));
      end else begin
        g = 320'(key_q & ~msk_q[0]);
        e = 320'(exp_q.pop_front() & ~msk_q[0]);
        void'(msk_q.pop_front());
        chk(g[306:241], e[306:241]);
        chk(g[240:232], e[240:232]);
        chk(g[231:160], e[231:160]);
        chk(g[159:0], e[159:0]);
      end
    end
  end

  initial begin
    for (int i = 0; i < NUM_RNG; i++) begin
      bnd_m[i] = 32'h0;
      kind_m[i] = 3'h0;
    end
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(REG_CTRL);
    rd(REG_LABEL_SKIP);
    wr(REG_STATUS, 32'hFFFFFFFF);
    wr(8'h10, 32'hFFFFFFFF);
    rd(REG_STATUS);
    rd(8'h10);
    for (int t = 0; t < 4; t++) burst(40, 2'(t));
    drain();
    rd(REG_STATUS);
    // One range per kind, bounds sized so about half of the values match
    for (int i = 0; i < NUM_RNG; i++) begin
      wr(REG_RNG_KIND + 8'(4 * i), 32'(i));
      wr(REG_RNG_BOUND + 8'(4 * i), i == 3 ? 32'h0BFF0400 :
         i == 4 ? 32'h002F0010 : 32'hBFFF4000);
      rd(REG_RNG_KIND + 8'(4 * i));
      rd(REG_RNG_BOUND + 8'(4 * i));
    end
    for (int c = 0; c < 3; c++) begin
      wr(REG_CTRL, c == 2 ? 32'h000000FF : $random(seed));
      wr(REG_LABEL_SKIP, $random(seed));
      rd(REG_CTRL);
      rd(REG_LABEL_SKIP);
      for (int t = 0; t < 4; t++) burst(50, 2'(t));
      drain();
      rd(REG_STATUS);
    end
    tally_and_finish();
  end
endmodule // x4k_key_builder_tb

// file: test/x4k_parser_model.sv
// Frame parser stand-in that replays queued frames one per clock
`timescale 1ns/1ps
module x4k_parser_model
  import x4k_pkg::*;
(
  input  wire logic clk_sys,
  output x4k_frame_t frame_q
);
  x4k_frame_t pend_q [$];

  initial frame_q = '0;

  // Idle fields flip every cycle so stale frame contents never look valid
  always @(posedge clk_sys) begin
    if (pend_q.size() > 0) begin
      frame_q <= pend_q.pop_front();
    end else begin
      frame_q <= {1'b0, ~frame_q[$bits(x4k_frame_t)-2:0]};
    end
  end
endmodule // x4k_parser_model
